//--- core/ppm_map.svh
// Function
// - Control A bit 5 set moves the second logic-table output to its alternative pin.
// - Control A bit 4 set moves the first logic-table output to its alternative pin.
// - Control A bit 2 set drives the third event output onto its pin, else it stays off.
// - Control A bit 1 set drives the second event output onto its pin, else it stays off.
// - Control A bit 0 set drives the first event output onto its pin, else it stays off.
// - Control B bit 2 set moves every SPI signal to the alternative pin set.
// - Control B bit 0 set moves every async serial signal to the alternative pin set.
// - Control C bit 3 moves timer A wave 3 to its alternative pin only in split mode.
// - Control C bit 2 moves timer A wave 2 (low byte channel 2 in split) to its alt pin.
// - Control C bit 1 moves timer A wave 1 (low byte channel 1 in split) to its alt pin.
// - Control C bit 0 moves timer A wave 0 (low byte channel 0 in split) to its alt pin.
// - Control D bit 0 moves the timer B output to its alternative pin.
`ifndef PPM_MAP_SVH
`define PPM_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices, byte address is four times the index
`define PPM_IDX_CTRL_A 3'h0
`define PPM_IDX_CTRL_B 3'h1
`define PPM_IDX_CTRL_C 3'h2
`define PPM_IDX_CTRL_D 3'h3
`define PPM_IDX_STATUS 3'h4

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define PPM_SECOND_LOGIC_TABLE_ALT_PIN 5
`define PPM_FIRST_LOGIC_TABLE_ALT_PIN  4
`define PPM_EVENT_PIN_OUT_TWO_ENABLE   2
`define PPM_EVENT_PIN_OUT_ONE_ENABLE   1
`define PPM_EVENT_PIN_OUT_ZERO_ENABLE  0
`define PPM_SERIAL_PERIPHERAL_ALT_PINS 2
`define PPM_ASYNC_SERIAL_ALT_PINS      0
`define PPM_TIMER_A_WAVE3_ALT_PIN      3
`define PPM_TIMER_B_OUTPUT_ALT_PIN     0
`define PPM_STAT_SPLIT_MODE            0
`define PPM_STAT_WAVE3_ALT_ACTIVE      1

////////////////////////////////////////////////////////////////////////////////
// Writable bit masks and reset values
`define PPM_MASK_CTRL_A 8'h37
`define PPM_MASK_CTRL_B 8'h05
`define PPM_MASK_CTRL_C 8'h0F
`define PPM_MASK_CTRL_D 8'h01
`define PPM_RESET_CTRL  8'h00
`define PPM_RDATA_ZERO  32'h0000_0000

`endif

//--- core/ppm_pkg.sv
`default_nettype none
package ppm_pkg;
  `include "ppm_map.svh"

  // One control byte
  typedef logic [7:0] ppm_ctrl_type;

  // One-hot register select from the address decoder
  typedef enum logic [5:0]
  {
    PPM_SEL_NONE   = 6'b00_0001,
    PPM_SEL_CTRL_A = 6'b00_0010,
    PPM_SEL_CTRL_B = 6'b00_0100,
    PPM_SEL_CTRL_C = 6'b00_1000,
    PPM_SEL_CTRL_D = 6'b01_0000,
    PPM_SEL_STATUS = 6'b10_0000
  } ppm_sel_type;
endpackage
`default_nettype wire

//--- core/ppm_route_cell.sv
`default_nettype none
// Steers one peripheral signal group to its default or alternative pins
module ppm_route_cell
  import ppm_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         alt_sel_i,
  input  wire logic [W-1:0] periph_out_i,
  input  wire logic [W-1:0] periph_oe_i,
  input  wire logic [W-1:0] dflt_pin_in_i,
  input  wire logic [W-1:0] alt_pin_in_i,
  output logic      [W-1:0] dflt_pin_out_o,
  output logic      [W-1:0] dflt_pin_oe_o,
  output logic      [W-1:0] alt_pin_out_o,
  output logic      [W-1:0] alt_pin_oe_o,
  output logic      [W-1:0] periph_in_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Outgoing path: the unselected pin set is released, never driven low
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dflt_pin_out_o <= '0;
      dflt_pin_oe_o  <= '0;
      alt_pin_out_o  <= '0;
      alt_pin_oe_o   <= '0;
    end
    else
    begin
      dflt_pin_out_o <= alt_sel_i ? '0 : periph_out_i;
      dflt_pin_oe_o  <= alt_sel_i ? '0 : periph_oe_i;
      alt_pin_out_o  <= alt_sel_i ? periph_out_i : '0;
      alt_pin_oe_o   <= alt_sel_i ? periph_oe_i : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Incoming path: only the selected pin set reaches the peripheral
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      periph_in_o <= '0;
    end
    else
    begin
      periph_in_o <= alt_sel_i ? alt_pin_in_i : dflt_pin_in_i;
    end
  end

endmodule
`default_nettype wire

//--- core/ppm_pin_mux.sv
// The APB interface to the registers was left to the implementer.
`default_nettype none
`include "ppm_map.svh"
// Peripheral pin location multiplexer with APB register access
module ppm_pin_mux
  import ppm_pkg::*;
#(
  parameter int ADDR_W = 5,
  parameter int SPI_W  = 4,
  parameter int UART_W = 3
)
(
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Logic-table outputs
  input  wire logic [1:0]        lut_out_i,
  input  wire logic [1:0]        lut_oe_i,
  output logic      [1:0]        lut_dflt_pin_out_o,
  output logic      [1:0]        lut_dflt_pin_oe_o,
  output logic      [1:0]        lut_alt_pin_out_o,
  output logic      [1:0]        lut_alt_pin_oe_o,
  // Event outputs
  input  wire logic [2:0]        evt_i,
  output logic      [2:0]        evt_pin_out_o,
  output logic      [2:0]        evt_pin_oe_o,
  // SPI group
  input  wire logic [SPI_W-1:0]  spi_out_i,
  input  wire logic [SPI_W-1:0]  spi_oe_i,
  input  wire logic [SPI_W-1:0]  spi_dflt_pin_in_i,
  input  wire logic [SPI_W-1:0]  spi_alt_pin_in_i,
  output logic      [SPI_W-1:0]  spi_dflt_pin_out_o,
  output logic      [SPI_W-1:0]  spi_dflt_pin_oe_o,
  output logic      [SPI_W-1:0]  spi_alt_pin_out_o,
  output logic      [SPI_W-1:0]  spi_alt_pin_oe_o,
  output logic      [SPI_W-1:0]  spi_in_o,
  // Async serial group
  input  wire logic [UART_W-1:0] uart_out_i,
  input  wire logic [UART_W-1:0] uart_oe_i,
  input  wire logic [UART_W-1:0] uart_dflt_pin_in_i,
  input  wire logic [UART_W-1:0] uart_alt_pin_in_i,
  output logic      [UART_W-1:0] uart_dflt_pin_out_o,
  output logic      [UART_W-1:0] uart_dflt_pin_oe_o,
  output logic      [UART_W-1:0] uart_alt_pin_out_o,
  output logic      [UART_W-1:0] uart_alt_pin_oe_o,
  output logic      [UART_W-1:0] uart_in_o,
  // Timer A waveforms
  input  wire logic              split_mode_i,
  input  wire logic [3:0]        wave_out_i,
  input  wire logic [3:0]        wave_oe_i,
  output logic      [3:0]        wave_dflt_pin_out_o,
  output logic      [3:0]        wave_dflt_pin_oe_o,
  output logic      [3:0]        wave_alt_pin_out_o,
  output logic      [3:0]        wave_alt_pin_oe_o,
  // Timer B output
  input  wire logic              tmr_b_out_i,
  input  wire logic              tmr_b_oe_i,
  output logic                   tmr_b_dflt_pin_out_o,
  output logic                   tmr_b_dflt_pin_oe_o,
  output logic                   tmr_b_alt_pin_out_o,
  output logic                   tmr_b_alt_pin_oe_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode a byte address into a one-hot register select
  function automatic ppm_sel_type ppm_decode(input logic [ADDR_W-1:0] addr);
    logic [2:0] idx;
    idx = 3'(addr >> 2);
    if (addr[1:0] != 2'b00 || (addr >> 2) > ADDR_W'(`PPM_IDX_STATUS))
      return PPM_SEL_NONE;
    unique case (idx)
      `PPM_IDX_CTRL_A: return PPM_SEL_CTRL_A;
      `PPM_IDX_CTRL_B: return PPM_SEL_CTRL_B;
      `PPM_IDX_CTRL_C: return PPM_SEL_CTRL_C;
      `PPM_IDX_CTRL_D: return PPM_SEL_CTRL_D;
      `PPM_IDX_STATUS: return PPM_SEL_STATUS;
      default:         return PPM_SEL_NONE;
    endcase
  endfunction

  // Next value of a control byte: only implemented bits take the write
  function automatic ppm_ctrl_type ppm_masked(input ppm_ctrl_type mask,
                                              input logic [7:0]   wdata);
    return wdata & mask;
  endfunction

  ppm_ctrl_type ctrl_a;
  ppm_ctrl_type ctrl_b;
  ppm_ctrl_type ctrl_c;
  ppm_ctrl_type ctrl_d;
  ppm_sel_type  setup_sel;
  ppm_sel_type  access_sel;
  logic         setup_phase;
  logic         wr_commit;
  logic         wave3_alt_active;
  logic [3:0]   next_wave_sel;
  logic [7:0]   status_byte;
  logic [31:0]  next_rdata;

  assign setup_phase = psel_i && !penable_i;
  assign setup_sel   = ppm_decode(paddr_i);
  // A write lands at the edge where the master sees pready high
  assign wr_commit   = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0]
                       && !pslverr_o;

  ////////////////////////////////////////////////////////////////////////////////
  // APB answer: decoded in setup, so pready and read data come from flops
  always_comb
  begin
    next_rdata = `PPM_RDATA_ZERO;
    unique case (setup_sel)
      PPM_SEL_CTRL_A: next_rdata = {24'h00_0000, ctrl_a};
      PPM_SEL_CTRL_B: next_rdata = {24'h00_0000, ctrl_b};
      PPM_SEL_CTRL_C: next_rdata = {24'h00_0000, ctrl_c};
      PPM_SEL_CTRL_D: next_rdata = {24'h00_0000, ctrl_d};
      PPM_SEL_STATUS: next_rdata = {24'h00_0000, status_byte};
      PPM_SEL_NONE:   next_rdata = `PPM_RDATA_ZERO;
    endcase
  end

  // Access phase always lasts exactly one cycle
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pready_o   <= 1'b0;
      pslverr_o  <= 1'b0;
      prdata_o   <= `PPM_RDATA_ZERO;
      access_sel <= PPM_SEL_NONE;
    end
    else
    begin
      pready_o   <= setup_phase;
      pslverr_o  <= setup_phase && (setup_sel == PPM_SEL_NONE);
      access_sel <= setup_phase ? setup_sel : PPM_SEL_NONE;
      if (setup_phase && !pwrite_i)
      begin
        prdata_o <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers; status is read-only so writes to it are dropped
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl_a <= `PPM_RESET_CTRL;
      ctrl_b <= `PPM_RESET_CTRL;
      ctrl_c <= `PPM_RESET_CTRL;
      ctrl_d <= `PPM_RESET_CTRL;
    end
    else if (wr_commit)
    begin
      unique case (access_sel)
        PPM_SEL_CTRL_A: ctrl_a <= ppm_masked(`PPM_MASK_CTRL_A, pwdata_i[7:0]);
        PPM_SEL_CTRL_B: ctrl_b <= ppm_masked(`PPM_MASK_CTRL_B, pwdata_i[7:0]);
        PPM_SEL_CTRL_C: ctrl_c <= ppm_masked(`PPM_MASK_CTRL_C, pwdata_i[7:0]);
        PPM_SEL_CTRL_D: ctrl_d <= ppm_masked(`PPM_MASK_CTRL_D, pwdata_i[7:0]);
        PPM_SEL_STATUS: ctrl_d <= ctrl_d;
        PPM_SEL_NONE:   ctrl_d <= ctrl_d;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status shows the live timer mode and whether wave 3 really moved
  assign wave3_alt_active = ctrl_c[`PPM_TIMER_A_WAVE3_ALT_PIN] && split_mode_i;
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[`PPM_STAT_SPLIT_MODE]       = split_mode_i;
    status_byte[`PPM_STAT_WAVE3_ALT_ACTIVE] = wave3_alt_active;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event outputs: a disabled channel releases its pin and reads low
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      evt_pin_out_o <= 3'h0;
      evt_pin_oe_o  <= 3'h0;
    end
    else
    begin
      evt_pin_oe_o  <= ctrl_a[2:0];
      evt_pin_out_o <= evt_i & ctrl_a[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Logic-table outputs, one cell each
  for (genvar g = 0; g < 2; g++)
  begin : g_lut
    ppm_route_cell #(.W(1)) u_lut
    (
      .sys_clk_i      (sys_clk_i),
      .nrst_i         (nrst_i),
      .alt_sel_i      (ctrl_a[`PPM_FIRST_LOGIC_TABLE_ALT_PIN + g]),
      .periph_out_i   (lut_out_i[g]),
      .periph_oe_i    (lut_oe_i[g]),
      .dflt_pin_in_i  (1'b0),
      .alt_pin_in_i   (1'b0),
      .dflt_pin_out_o (lut_dflt_pin_out_o[g]),
      .dflt_pin_oe_o  (lut_dflt_pin_oe_o[g]),
      .alt_pin_out_o  (lut_alt_pin_out_o[g]),
      .alt_pin_oe_o   (lut_alt_pin_oe_o[g]),
      .periph_in_o    ()
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Whole SPI group moves together so no signal is left on the old pins
  ppm_route_cell #(.W(SPI_W)) u_spi
  (
    .sys_clk_i      (sys_clk_i),
    .nrst_i         (nrst_i),
    .alt_sel_i      (ctrl_b[`PPM_SERIAL_PERIPHERAL_ALT_PINS]),
    .periph_out_i   (spi_out_i),
    .periph_oe_i    (spi_oe_i),
    .dflt_pin_in_i  (spi_dflt_pin_in_i),
    .alt_pin_in_i   (spi_alt_pin_in_i),
    .dflt_pin_out_o (spi_dflt_pin_out_o),
    .dflt_pin_oe_o  (spi_dflt_pin_oe_o),
    .alt_pin_out_o  (spi_alt_pin_out_o),
    .alt_pin_oe_o   (spi_alt_pin_oe_o),
    .periph_in_o    (spi_in_o)
  );

  // Async serial group
  ppm_route_cell #(.W(UART_W)) u_uart
  (
    .sys_clk_i      (sys_clk_i),
    .nrst_i         (nrst_i),
    .alt_sel_i      (ctrl_b[`PPM_ASYNC_SERIAL_ALT_PINS]),
    .periph_out_i   (uart_out_i),
    .periph_oe_i    (uart_oe_i),
    .dflt_pin_in_i  (uart_dflt_pin_in_i),
    .alt_pin_in_i   (uart_alt_pin_in_i),
    .dflt_pin_out_o (uart_dflt_pin_out_o),
    .dflt_pin_oe_o  (uart_dflt_pin_oe_o),
    .alt_pin_out_o  (uart_alt_pin_out_o),
    .alt_pin_oe_o   (uart_alt_pin_oe_o),
    .periph_in_o    (uart_in_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Timer A waves; in split mode 0..2 are the low-byte compare channels
  always_comb
  begin
    next_wave_sel    = ctrl_c[3:0];
    next_wave_sel[3] = wave3_alt_active;
  end

  for (genvar w = 0; w < 4; w++)
  begin : g_wave
    ppm_route_cell #(.W(1)) u_wave
    (
      .sys_clk_i      (sys_clk_i),
      .nrst_i         (nrst_i),
      .alt_sel_i      (next_wave_sel[w]),
      .periph_out_i   (wave_out_i[w]),
      .periph_oe_i    (wave_oe_i[w]),
      .dflt_pin_in_i  (1'b0),
      .alt_pin_in_i   (1'b0),
      .dflt_pin_out_o (wave_dflt_pin_out_o[w]),
      .dflt_pin_oe_o  (wave_dflt_pin_oe_o[w]),
      .alt_pin_out_o  (wave_alt_pin_out_o[w]),
      .alt_pin_oe_o   (wave_alt_pin_oe_o[w]),
      .periph_in_o    ()
    );
  end

  // Timer B output
  ppm_route_cell #(.W(1)) u_tmr_b
  (
    .sys_clk_i      (sys_clk_i),
    .nrst_i         (nrst_i),
    .alt_sel_i      (ctrl_d[`PPM_TIMER_B_OUTPUT_ALT_PIN]),
    .periph_out_i   (tmr_b_out_i),
    .periph_oe_i    (tmr_b_oe_i),
    .dflt_pin_in_i  (1'b0),
    .alt_pin_in_i   (1'b0),
    .dflt_pin_out_o (tmr_b_dflt_pin_out_o),
    .dflt_pin_oe_o  (tmr_b_dflt_pin_oe_o),
    .alt_pin_out_o  (tmr_b_alt_pin_out_o),
    .alt_pin_oe_o   (tmr_b_alt_pin_oe_o),
    .periph_in_o    ()
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks: routing follows the control bits one cycle later
  a_second_logic_table_alt_pin_alt_route: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    ctrl_a[`PPM_SECOND_LOGIC_TABLE_ALT_PIN]
    |=> lut_alt_pin_out_o[1] == $past(lut_out_i[1]) && !lut_dflt_pin_oe_o[1])
    else $error("second logic table not on its alternative pin");

  a_first_logic_table_alt_pin_dflt_route: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !ctrl_a[`PPM_FIRST_LOGIC_TABLE_ALT_PIN]
    |=> lut_dflt_pin_oe_o[0] == $past(lut_oe_i[0]) && !lut_alt_pin_oe_o[0])
    else $error("first logic table not on its default pin");

  a_evt2_gate: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    evt_pin_oe_o[2] == $past(ctrl_a[`PPM_EVENT_PIN_OUT_TWO_ENABLE])
    && (evt_pin_out_o[2] == ($past(evt_i[2]) && evt_pin_oe_o[2])))
    else $error("event output two gating wrong");

  a_evt1_gate: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(ctrl_a[`PPM_EVENT_PIN_OUT_ONE_ENABLE]) |=> evt_pin_oe_o[1])
    else $error("event output one not enabled after write");

  a_evt0_off: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !ctrl_a[`PPM_EVENT_PIN_OUT_ZERO_ENABLE] [*2] |-> !evt_pin_oe_o[0] && !evt_pin_out_o[0])
    else $error("event output zero driven while disabled");

  a_spi_group_move: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    ctrl_b[`PPM_SERIAL_PERIPHERAL_ALT_PINS]
    |=> spi_dflt_pin_oe_o == '0 && spi_alt_pin_oe_o == $past(spi_oe_i)
        && spi_in_o == $past(spi_alt_pin_in_i))
    else $error("SPI group not fully on alternative pins");

  a_uart_group_move: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !ctrl_b[`PPM_ASYNC_SERIAL_ALT_PINS]
    |=> uart_alt_pin_oe_o == '0 && uart_in_o == $past(uart_dflt_pin_in_i))
    else $error("async serial group left default pins");

  a_wave3_normal_mode: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !split_mode_i |=> !wave_alt_pin_oe_o[3] && wave_dflt_pin_out_o[3] == $past(wave_out_i[3]))
    else $error("wave 3 moved while timer not in split mode");

  a_wave2_alt_route: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    ctrl_c[2] |=> wave_alt_pin_out_o[2] == $past(wave_out_i[2]) && !wave_dflt_pin_oe_o[2])
    else $error("wave 2 not on its alternative pin");

  a_wave1_alt_route: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    ctrl_c[1] |=> wave_alt_pin_oe_o[1] == $past(wave_oe_i[1]) && !wave_dflt_pin_oe_o[1])
    else $error("wave 1 not on its alternative pin");

  a_wave0_dflt_route: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !ctrl_c[0] |=> wave_dflt_pin_out_o[0] == $past(wave_out_i[0]) && !wave_alt_pin_oe_o[0])
    else $error("wave 0 not on its default pin");

  a_tmr_b_route: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    ctrl_d[`PPM_TIMER_B_OUTPUT_ALT_PIN] |=> tmr_b_alt_pin_oe_o == $past(tmr_b_oe_i)
                                           && !tmr_b_dflt_pin_oe_o)
    else $error("timer B output not on its alternative pin");

  a_unused_bits_zero: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (ctrl_a & ~`PPM_MASK_CTRL_A) == 8'h00 && (ctrl_b & ~`PPM_MASK_CTRL_B) == 8'h00
    && (ctrl_c & ~`PPM_MASK_CTRL_C) == 8'h00 && (ctrl_d & ~`PPM_MASK_CTRL_D) == 8'h00)
    else $error("unimplemented control bit became set");

  a_apb_one_wait: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    psel_i && !penable_i |=> pready_o)
    else $error("APB access phase not answered in one cycle");

endmodule
`default_nettype wire

//--- sim/ppm_periph_model.sv
`default_nettype none
// Stand-in for the peripherals and pin pads on the far side of the mux
module ppm_periph_model
(
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  output logic      [44:0] pat_o
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Odd step keeps most bits moving each cycle, so a stale mux path shows up
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pat_o <= 45'h0_1234_5678_9abc;
    else
      pat_o <= pat_o + 45'h0a5a_3c3c_9697;
  end
endmodule
`default_nettype wire

//--- sim/ppm_pin_mux_tb.sv
`default_nettype none
module ppm_pin_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [4:0]  paddr   = 5'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [3:0]  pstrb   = 4'h0;
  logic        split   = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er;
  logic [44:0] pat;
  logic [1:0]  l_o, l_e, l_do, l_de, l_ao, l_ae;
  logic [2:0]  ev, e_o, e_e, u_o, u_e, u_di, u_ai, u_do, u_de, u_ao, u_ae, u_in;
  logic [3:0]  s_o, s_e, s_di, s_ai, s_do, s_de, s_ao, s_ae, s_in;
  logic [3:0]  w_o, w_e, w_do, w_de, w_ao, w_ae;
  logic        t_o, t_e, t_do, t_de, t_ao, t_ae;
  logic [7:0]  ca, cb, cc, cd;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;

  assign {l_o, l_e, ev, s_o, s_e, s_di, s_ai, u_o, u_e, u_di, u_ai, w_o, w_e, t_o, t_e} = pat;

  always #20 sys_clk = ~sys_clk;

  ppm_periph_model i_ppm_periph_model (.sys_clk_i(sys_clk), .nrst_i(nrst), .pat_o(pat));

  ppm_pin_mux i_ppm_pin_mux (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .lut_out_i(l_o), .lut_oe_i(l_e), .lut_dflt_pin_out_o(l_do), .lut_dflt_pin_oe_o(l_de),
    .lut_alt_pin_out_o(l_ao), .lut_alt_pin_oe_o(l_ae),
    .evt_i(ev), .evt_pin_out_o(e_o), .evt_pin_oe_o(e_e),
    .spi_out_i(s_o), .spi_oe_i(s_e), .spi_dflt_pin_in_i(s_di), .spi_alt_pin_in_i(s_ai),
    .spi_dflt_pin_out_o(s_do), .spi_dflt_pin_oe_o(s_de), .spi_alt_pin_out_o(s_ao),
    .spi_alt_pin_oe_o(s_ae), .spi_in_o(s_in),
    .uart_out_i(u_o), .uart_oe_i(u_e), .uart_dflt_pin_in_i(u_di), .uart_alt_pin_in_i(u_ai),
    .uart_dflt_pin_out_o(u_do), .uart_dflt_pin_oe_o(u_de), .uart_alt_pin_out_o(u_ao),
    .uart_alt_pin_oe_o(u_ae), .uart_in_o(u_in),
    .split_mode_i(split), .wave_out_i(w_o), .wave_oe_i(w_e),
    .wave_dflt_pin_out_o(w_do), .wave_dflt_pin_oe_o(w_de), .wave_alt_pin_out_o(w_ao),
    .wave_alt_pin_oe_o(w_ae),
    .tmr_b_out_i(t_o), .tmr_b_oe_i(t_e), .tmr_b_dflt_pin_out_o(t_do),
    .tmr_b_dflt_pin_oe_o(t_de), .tmr_b_alt_pin_out_o(t_ao), .tmr_b_alt_pin_oe_o(t_ae));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and hang guard
  task automatic wrap_up();
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // APB master: request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Legal write that also updates the bench's copy of the controls
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'b00}, d, 4'h1, rd, er);
    chk("write error", 32'(er), 32'h0000_0000);
    case (i)
      3'h0: ca = d & 8'h37;
      3'h1: cb = d & 8'h05;
      3'h2: cc = d & 8'h0f;
      default: cd = d & 8'h01;
    endcase
  endtask

  // Selected pins carry the peripheral, the other set is parked at zero
  function automatic logic [19:0] route4(input logic [3:0] s, o, e, di, ai);
    return {~s & o, ~s & e, s & o, s & e, (s & ai) | (~s & di)};
  endfunction

  // Expectation built mid-cycle from live inputs, judged after the next edge
  task automatic chk_routes(input int n);
    logic [19:0] el, es, eu, ew, et;
    logic [5:0]  ee;
    repeat (n)
    begin
      @(negedge sys_clk);
      el = route4(4'(ca[5:4]), 4'(l_o), 4'(l_e), 4'h0, 4'h0);
      ee = {ev & ca[2:0], ca[2:0]};
      es = route4({4{cb[2]}}, s_o, s_e, s_di, s_ai);
      eu = route4({4{cb[0]}}, 4'(u_o), 4'(u_e), 4'(u_di), 4'(u_ai));
      ew = route4({cc[3] & split, cc[2:0]}, w_o, w_e, 4'h0, 4'h0);
      et = route4(4'(cd[0]), 4'(t_o), 4'(t_e), 4'h0, 4'h0);
      @(posedge sys_clk);
      #1;
      chk("lut", {12'h000, 4'(l_do), 4'(l_de), 4'(l_ao), 4'(l_ae), 4'h0}, 32'(el));
      chk("event", 32'({e_o, e_e}), 32'(ee));
      chk("spi", 32'({s_do, s_de, s_ao, s_ae, s_in}), 32'(es));
      chk("uart", {12'h000, 4'(u_do), 4'(u_de), 4'(u_ao), 4'(u_ae), 4'(u_in)}, 32'(eu));
      chk("wave", 32'({w_do, w_de, w_ao, w_ae, 4'h0}), 32'(ew));
      chk("tmr_b", {12'h000, 4'(t_do), 4'(t_de), 4'(t_ao), 4'(t_ae), 4'h0}, 32'(et));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 5'(i * 4), 8'h00, 4'h0, rd, er);
      chk("reset value", rd, 32'h0000_0000);
    end
    chk_routes(3);
  endtask

  task automatic t_masks();
    logic [7:0] m [4] = '{8'h37, 8'h05, 8'h0f, 8'h01};
    for (int i = 0; i < 4; i++)
    begin
      wr(3'(i), 8'hff);
      apb(1'b0, 5'(i * 4), 8'h00, 4'h0, rd, er);
      chk("masked readback", rd, {24'h00_0000, m[i]});
    end
    chk_routes(3);
    // Strobe low and a misaligned address must leave control B alone
    apb(1'b1, 5'h04, 8'h00, 4'h0, rd, er);
    apb(1'b1, 5'h05, 8'h00, 4'h1, rd, er);
    chk("misaligned error", 32'(er), 32'h0000_0001);
    apb(1'b0, 5'h04, 8'h00, 4'h0, rd, er);
    chk("ignored writes", rd, 32'h0000_0005);
    apb(1'b0, 5'h14, 8'h00, 4'h0, rd, er);
    chk("unmapped error", 32'(er), 32'h0000_0001);
  endtask

  // One control bit at a time, split mode toggling; wave 3's alt bit (control C bit 3) is tried with split on only, while C holds 0x08
  task automatic t_bits();
    for (int i = 0; i < 4; i++)
      for (int b = 0; b < 8; b++)
      begin
        wr(3'(i), 8'(1 << b));
        split <= b[1];
        chk_routes(2);
      end
  endtask

  task automatic t_split();
    wr(3'h2, 8'h08);
    for (int s = 0; s < 2; s++)
    begin
      split <= 1'(s);
      chk_routes(2);
      apb(1'b1, 5'h10, 8'hff, 4'h1, rd, er);
      apb(1'b0, 5'h10, 8'h00, 4'h0, rd, er);
      chk("status", rd, 32'(s * 3));
    end
    // Reset in mid-run must drop every control back to default
    wr(3'h0, 8'h37);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    {ca, cb, cc, cd} = 32'h0000_0000;
    apb(1'b0, 5'h00, 8'h00, 4'h0, rd, er);
    chk("second reset", rd, 32'h0000_0000);
    chk_routes(2);
  endtask

  initial
  begin
    {ca, cb, cc, cd} = 32'h0000_0000;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_masks();
    t_bits();
    t_split();
    wrap_up();
  end
endmodule
`default_nettype wire
